// ==== design/dpbm_top.sv ====
// dual-port block memory with fifo controller, ecc and cascade path
// assumes user logic on aclk drives both ports; config over axi4-lite
`timescale 1ns/1ps
`default_nettype none
module dpbm_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ena,
  input wire logic wea,
  input wire logic [15:0] addra,
  input wire logic [71:0] dina,
  output logic [71:0] douta,
  input wire logic enb,
  input wire logic web,
  input wire logic [15:0] addrb,
  input wire logic [71:0] dinb,
  output logic [71:0] doutb,
  output logic sbiterr,
  output logic dbiterr,
  input wire logic sleep,
  output logic fifo_full,
  output logic fifo_empty,
  output logic fifo_almost_full,
  output logic fifo_almost_empty,
  input wire logic [63:0] ecc_enc_data,
  output logic [7:0] ecc_enc_check,
  input wire logic [71:0] ecc_dec_word,
  output logic [63:0] ecc_dec_data,
  output logic ecc_dec_sbe,
  output logic ecc_dec_dbe,
  input wire logic [71:0] casc_in,
  output logic [71:0] casc_out
);

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic arready;
    logic rvalid;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [7:0] aw_addr;
    logic have_aw;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic have_w;
    logic [dpbm_pkg::CTRL_W-1:0] ctrl;
    logic [7:0] width;
    logic [12:0] af;
    logic [12:0] ae;
    logic slp;
    logic ena;
    logic wea;
    logic enb;
    logic web;
    logic [15:0] addra;
    logic [15:0] addrb;
    logic [71:0] dina;
    logic [71:0] dinb;
    logic [71:0] douta_lat;
    logic [71:0] doutb_lat;
    logic [71:0] douta;
    logic [71:0] doutb;
    logic sbe_lat;
    logic dbe_lat;
    logic sbe;
    logic dbe;
    logic [12:0] wp;
    logic [12:0] rp;
    logic [12:0] wp_gray;
    logic [12:0] rp_gray;
    logic [12:0] wp_gray_a;
    logic [12:0] rp_gray_a;
    logic [12:0] wp_gray_b;
    logic [12:0] rp_gray_b;
    logic full;
    logic empty;
    logic afull;
    logic aempty;
    logic [7:0] enc_chk;
    logic [63:0] dec_data;
    logic dec_sbe;
    logic dec_dbe;
  } dpbm_state_t;

  dpbm_state_t s;
  dpbm_state_t next_s;

  // 4096 lanes of 9 bits, all that the two ports share
  logic [dpbm_pkg::LANE_W-1:0] mem [dpbm_pkg::LANES];

  logic wr_en [2];
  logic [11:0] wr_lane [2];
  logic [2:0] wr_code [2];
  logic [2:0] wr_off [2];
  logic [71:0] wr_data [2];
  logic split, wide, oreg, nolatch, ecc, fifo, dual, casc;
  logic [2:0] code_a, code_b;
  logic [3:0] la, lb;
  logic [11:0] mask;
  logic [12:0] depth, seen_wp, seen_rp;
  logic [14:0] loc_a, loc_b;
  logic [11:0] lane_a, lane_b;
  logic local_a, local_b, act, wr_a, rd_a, wr_b, rd_b, remote_b;
  logic [71:0] raw_a, raw_b, data_a;
  logic [65:0] fix_b, dfix;
  logic [31:0] rd_val;

  // lanes covered by one word of a width code
  function automatic logic [3:0] lanes_of(input logic [2:0] code);
    return (code >= dpbm_pkg::W9) ? 4'(4'h1 << (code - dpbm_pkg::W9)) : 4'h1;
  endfunction : lanes_of

  // clamp a requested width to what the current mode allows
  function automatic logic [2:0] eff_code(input logic [2:0] code, input logic sp,
                                          input logic wd, input logic fixed,
                                          input logic ff);
    logic [2:0] cap;
    logic [2:0] c;
    cap = wd ? (sp ? dpbm_pkg::W36 : dpbm_pkg::W72) : (sp ? dpbm_pkg::W18 : dpbm_pkg::W36);
    c = (fixed || code > cap) ? cap : code;
    if (ff && c < dpbm_pkg::W9) c = dpbm_pkg::W9; // fifo pointers count whole lanes
    return c;
  endfunction : eff_code

  // word address to {bit offset, first lane}
  function automatic logic [14:0] locate(input logic [14:0] addr, input logic [2:0] code,
                                         input logic sp, input logic half);
    logic [11:0] lane;
    logic [2:0] off;
    logic [14:0] low;
    low = 15'h0;
    if (code >= dpbm_pkg::W9) begin
      lane = 12'(addr << (code - dpbm_pkg::W9));
      off = 3'h0;
    end else begin
      lane = 12'(addr >> (dpbm_pkg::W9 - code));
      low = addr & ((15'h1 << (dpbm_pkg::W9 - code)) - 15'h1);
      off = 3'(low << code);
    end
    if (sp) lane[11] = half;
    return {off, lane};
  endfunction : locate

  // assemble one word from the array
  function automatic logic [71:0] rd_word(input logic [11:0] lane0, input logic [2:0] code,
                                          input logic [2:0] off, input logic [11:0] msk);
    logic [71:0] w;
    w = 72'h0;
    for (int l = 0; l < dpbm_pkg::MAX_LANES; l++) begin
      if (code >= dpbm_pkg::W9 && l < int'(lanes_of(code)))
        w[l*dpbm_pkg::LANE_W +: dpbm_pkg::LANE_W] = mem[(lane0 + 12'(l)) & msk];
    end
    for (int b = 0; b < dpbm_pkg::NARROW_BITS; b++) begin
      if (code < dpbm_pkg::W9 && b < (1 << code)) w[b] = mem[lane0][off + 3'(b)];
    end
    return w;
  endfunction : rd_word

  // keep only the bits of a word that the width code carries
  function automatic logic [71:0] trim(input logic [71:0] d, input logic [2:0] code);
    logic [6:0] n;
    n = (code >= dpbm_pkg::W9) ? 7'(lanes_of(code) * dpbm_pkg::LANE_W) : 7'(4'h1 << code);
    return d & ((72'h1 << n) - 72'h1);
  endfunction : trim

  // hamming check bits: 7 position bits plus overall parity
  function automatic logic [7:0] ecc_gen(input logic [63:0] d);
    logic [7:0] c;
    int j;
    c = 8'h0;
    j = 0;
    for (int p = 1; p < dpbm_pkg::ECC_CODE_LEN; p++) begin
      if ((p & (p - 1)) != 0) begin
        for (int k = 0; k < dpbm_pkg::ECC_SYN_W; k++) begin
          if (p[k]) c[k] = c[k] ^ d[j];
        end
        j++;
      end
    end
    c[7] = ^{c[6:0], d};
    return c;
  endfunction : ecc_gen

  // {double error, single error, corrected data} from {check, data}
  function automatic logic [65:0] ecc_fix(input logic [71:0] w);
    logic [63:0] d;
    logic [7:0] syn;
    logic total;
    int j;
    d = w[63:0];
    syn = ecc_gen(d) ^ w[71:64];
    total = ^w;
    j = 0;
    for (int p = 1; p < dpbm_pkg::ECC_CODE_LEN; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (total && syn[6:0] == 7'(p)) d[j] = ~w[j];
        j++;
      end
    end
    return {!total && syn[6:0] != 7'h0, total, d};
  endfunction : ecc_fix

  // spread data and check bits over the eight 9-bit lanes
  function automatic logic [71:0] pack_ecc(input logic [63:0] d);
    logic [7:0] c;
    logic [71:0] w;
    c = ecc_gen(d);
    w = 72'h0;
    for (int l = 0; l < dpbm_pkg::MAX_LANES; l++)
      w[l*dpbm_pkg::LANE_W +: dpbm_pkg::LANE_W] = {c[l], d[l*8 +: 8]};
    return w;
  endfunction : pack_ecc

  function automatic logic [12:0] bin2gray(input logic [12:0] b);
    return b ^ (b >> 1);
  endfunction : bin2gray

  function automatic logic [12:0] gray2bin(input logic [12:0] g);
    logic [12:0] b;
    b[12] = g[12];
    for (int i = 11; i >= 0; i--) b[i] = b[i+1] ^ g[i];
    return b;
  endfunction : gray2bin

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction : merge

  // all next-state logic
  always_comb begin
    next_s = s;
    // axi write: aw and w in either order, answer after both
    if (s.have_aw && s.have_w && !s.bvalid) begin
      next_s.bvalid = 1'b1;
      next_s.have_aw = 1'b0;
      next_s.have_w = 1'b0;
      next_s.bresp = dpbm_pkg::RESP_OKAY;
      case (s.aw_addr)
        dpbm_pkg::REG_CTRL:
          next_s.ctrl = dpbm_pkg::CTRL_W'(merge(32'(s.ctrl), s.w_data, s.w_strb));
        dpbm_pkg::REG_WIDTH: next_s.width = 8'(merge(32'(s.width), s.w_data, s.w_strb));
        dpbm_pkg::REG_THRESH: begin
          rd_val = merge({3'h0, s.ae, 3'h0, s.af}, s.w_data, s.w_strb);
          next_s.af = rd_val[dpbm_pkg::THR_AF_LSB +: 13];
          next_s.ae = rd_val[dpbm_pkg::THR_AE_LSB +: 13];
        end
        dpbm_pkg::REG_STATUS: next_s.bresp = dpbm_pkg::RESP_OKAY; // read-only, write dropped
        default: next_s.bresp = dpbm_pkg::RESP_DECERR;
      endcase
    end
    if (s.bvalid && s_axi_bready) next_s.bvalid = 1'b0;
    if (s_axi_awvalid && s.awready) begin
      next_s.have_aw = 1'b1;
      next_s.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wready) begin
      next_s.have_w = 1'b1;
      next_s.w_data = s_axi_wdata;
      next_s.w_strb = s_axi_wstrb;
    end
    next_s.awready = !next_s.have_aw && !next_s.bvalid;
    next_s.wready = !next_s.have_w && !next_s.bvalid;
    // axi read: one at a time, data a cycle after the address
    rd_val = 32'h0;
    rd_val[12:0] = s.wp - s.rp;
    rd_val[dpbm_pkg::ST_FULL] = s.full;
    rd_val[dpbm_pkg::ST_EMPTY] = s.empty;
    rd_val[dpbm_pkg::ST_AFULL] = s.afull;
    rd_val[dpbm_pkg::ST_AEMPTY] = s.aempty;
    rd_val[dpbm_pkg::ST_SBE] = s.sbe;
    rd_val[dpbm_pkg::ST_DBE] = s.dbe;
    if (s_axi_arvalid && s.arready) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = dpbm_pkg::RESP_OKAY;
      case (s_axi_araddr)
        dpbm_pkg::REG_CTRL: next_s.rdata = 32'(s.ctrl);
        dpbm_pkg::REG_WIDTH: next_s.rdata = 32'(s.width);
        dpbm_pkg::REG_THRESH: next_s.rdata = {3'h0, s.ae, 3'h0, s.af};
        dpbm_pkg::REG_STATUS: next_s.rdata = rd_val;
        default: begin
          next_s.rdata = 32'h0;
          next_s.rresp = dpbm_pkg::RESP_DECERR;
        end
      endcase
    end
    if (s.rvalid && s_axi_rready) next_s.rvalid = 1'b0;
    next_s.arready = !next_s.rvalid;

    // configuration decode
    split = s.ctrl[dpbm_pkg::CTRL_SPLIT];
    wide = s.ctrl[dpbm_pkg::CTRL_WIDE];
    oreg = s.ctrl[dpbm_pkg::CTRL_OREG];
    nolatch = s.ctrl[dpbm_pkg::CTRL_NOLATCH];
    ecc = s.ctrl[dpbm_pkg::CTRL_ECC];
    fifo = s.ctrl[dpbm_pkg::CTRL_FIFO];
    dual = s.ctrl[dpbm_pkg::CTRL_DUAL];
    casc = s.ctrl[dpbm_pkg::CTRL_CASC];
    // each port has its own shape; wide mode pins the write side
    code_a = eff_code(s.width[dpbm_pkg::WIDTH_A_LSB +: 3], split, wide, wide, fifo);
    code_b = eff_code(s.width[dpbm_pkg::WIDTH_B_LSB +: 3], split, wide, 1'b0, fifo);
    la = lanes_of(code_a);
    lb = lanes_of(code_b);
    mask = (fifo && split) ? dpbm_pkg::MASK_HALF : dpbm_pkg::MASK_FULL;
    depth = split ? dpbm_pkg::DEPTH_HALF : dpbm_pkg::DEPTH_FULL;

    // input registers; address holds while the port is idle unless nolatch is set
    next_s.slp = sleep;
    next_s.ena = ena;
    next_s.wea = wea;
    next_s.dina = dina;
    next_s.enb = enb;
    next_s.web = web;
    next_s.dinb = dinb;
    next_s.addra = (ena || nolatch) ? addra : s.addra;
    next_s.addrb = (enb || nolatch) ? addrb : s.addrb;

    // operations on captured inputs; outside fifo mode split puts a low, b high
    loc_a = locate(s.addra[14:0], code_a, split, 1'b0);
    loc_b = locate(s.addrb[14:0], code_b, split, 1'b1);
    local_a = !casc || (s.addra[15] == s.ctrl[dpbm_pkg::CTRL_CASC_UPPER]);
    local_b = !casc || (s.addrb[15] == s.ctrl[dpbm_pkg::CTRL_CASC_UPPER]);
    lane_a = fifo ? (s.wp[11:0] & mask) : loc_a[11:0];
    lane_b = fifo ? (s.rp[11:0] & mask) : loc_b[11:0];
    act = !s.slp;
    // a full fifo refuses writes, an empty one reads
    wr_a = act && s.ena && s.wea && (fifo ? !s.full : local_a);
    rd_a = act && s.ena && !s.wea && !fifo && !wide && local_a;
    wr_b = act && s.enb && s.web && !fifo && !wide && local_b;
    rd_b = act && s.enb && (fifo ? !s.empty : ((!s.web || wide) && local_b));
    remote_b = act && s.enb && !fifo && !local_b && (!s.web || wide);
    data_a = (ecc && code_a == dpbm_pkg::W72) ? pack_ecc(s.dina[63:0]) : s.dina;
    raw_a = rd_word(lane_a, code_a, loc_a[14:12], mask);
    raw_b = rd_word(lane_b, code_b, loc_b[14:12], mask);
    fix_b = ecc_fix({raw_b[71], raw_b[62], raw_b[53], raw_b[44], raw_b[35], raw_b[26],
                     raw_b[17], raw_b[8], raw_b[70:63], raw_b[61:54], raw_b[52:45],
                     raw_b[43:36], raw_b[34:27], raw_b[25:18], raw_b[16:9], raw_b[7:0]});
    wr_en[0] = wr_a;
    wr_lane[0] = lane_a;
    wr_code[0] = code_a;
    wr_off[0] = loc_a[14:12];
    wr_data[0] = data_a;
    wr_en[1] = wr_b;
    wr_lane[1] = lane_b;
    wr_code[1] = code_b;
    wr_off[1] = loc_b[14:12];
    wr_data[1] = s.dinb;

    // port a output latch
    if (rd_a) begin
      next_s.douta_lat = raw_a;
    end else if (wr_a && !fifo) begin
      case (s.ctrl[dpbm_pkg::CTRL_WMODE_A +: 2])
        dpbm_pkg::WM_READ_FIRST: next_s.douta_lat = raw_a;
        dpbm_pkg::WM_WRITE_FIRST: next_s.douta_lat = trim(s.dina, code_a);
        default: next_s.douta_lat = s.douta_lat;
      endcase
    end
    // port b output latch, with correction on 64-bit ecc words
    if (rd_b && ecc && code_b == dpbm_pkg::W72) begin
      next_s.doutb_lat = {8'h0, fix_b[63:0]};
      next_s.sbe_lat = fix_b[64];
      next_s.dbe_lat = fix_b[65];
    end else if (rd_b) begin
      next_s.doutb_lat = raw_b;
      next_s.sbe_lat = 1'b0;
      next_s.dbe_lat = 1'b0;
    end else if (remote_b) begin
      next_s.doutb_lat = casc_in;
    end else if (wr_b) begin
      case (s.ctrl[dpbm_pkg::CTRL_WMODE_B +: 2])
        dpbm_pkg::WM_READ_FIRST: next_s.doutb_lat = raw_b;
        dpbm_pkg::WM_WRITE_FIRST: next_s.doutb_lat = trim(s.dinb, code_b);
        default: next_s.doutb_lat = s.doutb_lat;
      endcase
    end
    // optional pipeline stage: outputs trail the latch by one cycle
    next_s.douta = oreg ? s.douta_lat : next_s.douta_lat;
    next_s.doutb = oreg ? s.doutb_lat : next_s.doutb_lat;
    next_s.sbe = oreg ? s.sbe_lat : next_s.sbe_lat;
    next_s.dbe = oreg ? s.dbe_lat : next_s.dbe_lat;

    // fifo pointers count lanes, so write and read widths may differ
    if (fifo && wr_a) next_s.wp = s.wp + 13'(la);
    if (fifo && rd_b) next_s.rp = s.rp + 13'(lb);
    // gray copies pass two stages before the far side trusts them
    next_s.wp_gray = bin2gray(next_s.wp);
    next_s.rp_gray = bin2gray(next_s.rp);
    next_s.wp_gray_a = s.wp_gray;
    next_s.wp_gray_b = s.wp_gray_a;
    next_s.rp_gray_a = s.rp_gray;
    next_s.rp_gray_b = s.rp_gray_a;
    // lagging copies err towards full and empty
    seen_rp = dual ? gray2bin(s.rp_gray_b) : next_s.rp;
    seen_wp = dual ? gray2bin(s.wp_gray_b) : next_s.wp;
    next_s.full = ({1'b0, next_s.wp - seen_rp} + 14'(la)) > {1'b0, depth};
    next_s.empty = (seen_wp - next_s.rp) < 13'(lb);
    next_s.afull = (next_s.wp - next_s.rp) >= s.af;
    next_s.aempty = (next_s.wp - next_s.rp) <= s.ae;

    // standalone check-bit encoder and decoder for external memories
    dfix = ecc_fix(ecc_dec_word);
    next_s.enc_chk = ecc_gen(ecc_enc_data);
    next_s.dec_data = dfix[63:0];
    next_s.dec_sbe = dfix[64];
    next_s.dec_dbe = dfix[65];

    // synchronous reset
    if (!aresetn) begin
      next_s = '0;
      next_s.awready = 1'b1;
      next_s.wready = 1'b1;
      next_s.arready = 1'b1;
      next_s.ctrl = dpbm_pkg::CTRL_RESET;
      next_s.width = dpbm_pkg::WIDTH_RESET;
      next_s.af = dpbm_pkg::AF_RESET;
      next_s.ae = dpbm_pkg::AE_RESET;
      next_s.empty = 1'b1;
      next_s.aempty = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    s <= next_s;
  end

  // array writes; on a same-lane collision port b lands last and wins
  always_ff @(posedge aclk) begin
    for (int p = 0; p < 2; p++) begin
      if (wr_en[p]) begin
        for (int l = 0; l < dpbm_pkg::MAX_LANES; l++) begin
          if (wr_code[p] >= dpbm_pkg::W9 && l < int'(lanes_of(wr_code[p])))
            mem[(wr_lane[p] + 12'(l)) & mask] <=
              wr_data[p][l*dpbm_pkg::LANE_W +: dpbm_pkg::LANE_W];
        end
        for (int b = 0; b < dpbm_pkg::NARROW_BITS; b++) begin
          if (wr_code[p] < dpbm_pkg::W9 && b < (1 << wr_code[p]))
            mem[wr_lane[p]][wr_off[p] + 3'(b)] <= wr_data[p][b];
        end
      end
    end
  end

  // every output straight from the state register
  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bresp = s.bresp;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_arready = s.arready;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign s_axi_rvalid = s.rvalid;
  assign douta = s.douta;
  assign doutb = s.doutb;
  assign casc_out = s.doutb;
  assign sbiterr = s.sbe;
  assign dbiterr = s.dbe;
  assign fifo_full = s.full;
  assign fifo_empty = s.empty;
  assign fifo_almost_full = s.afull;
  assign fifo_almost_empty = s.aempty;
  assign ecc_enc_check = s.enc_chk;
  assign ecc_dec_data = s.dec_data;
  assign ecc_dec_sbe = s.dec_sbe;
  assign ecc_dec_dbe = s.dec_dbe;

endmodule : dpbm_top
`default_nettype wire

// ==== shared/dpbm_pkg.sv ====
// constants, register map and field layout of the dual-port block memory
// assumes one clock, registers reached over axi4-lite, user logic on both ports
// Summary of operation
// - 36 Kb array shared by two independent ports
// - one 36 Kb array or two 18 Kb halves
// - all port inputs captured in input registers
// - address held unless latching is switched off
// - optional output stage adds one read cycle
// - write output: old word, new word, or hold
// - sleep input gates the array off
// - port shapes 32Kx1 up to 512x72
// - each port picks its own aspect ratio
// - half arrays: 16Kx1 up to 512x36
// - widest shapes only in wide mode
// - wide mode: write side fixed at widest
// - 64-bit words carry eight hamming check bits
// - standalone check-bit encoder and decoder
// - fifo controller advances its own addresses
// - fifo flags: full, empty, almost full, almost empty
// - fifo write and read widths may differ
// - cascade path joins neighbouring instances
package dpbm_pkg;
  localparam int LANES = 4096;
  localparam int LANE_W = 9;
  localparam int MAX_LANES = 8;
  localparam int NARROW_BITS = 4;
  localparam int PTR_W = 13;
  localparam int ECC_CODE_LEN = 72;
  localparam int ECC_SYN_W = 7;
  localparam logic [11:0] MASK_FULL = 12'hfff;
  localparam logic [11:0] MASK_HALF = 12'h7ff;
  localparam logic [12:0] DEPTH_FULL = 13'h1000;
  localparam logic [12:0] DEPTH_HALF = 13'h0800;
  // width codes of a port
  localparam logic [2:0] W1 = 3'h0;
  localparam logic [2:0] W9 = 3'h3;
  localparam logic [2:0] W18 = 3'h4;
  localparam logic [2:0] W36 = 3'h5;
  localparam logic [2:0] W72 = 3'h6;
  // behaviour of a port output during a write
  localparam logic [1:0] WM_READ_FIRST = 2'h0;
  localparam logic [1:0] WM_WRITE_FIRST = 2'h1;
  // register byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_WIDTH = 8'h04;
  localparam logic [7:0] REG_THRESH = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  // control register fields
  localparam int CTRL_W = 13;
  localparam int CTRL_SPLIT = 0;
  localparam int CTRL_WIDE = 1;
  localparam int CTRL_OREG = 2;
  localparam int CTRL_NOLATCH = 3;
  localparam int CTRL_ECC = 4;
  localparam int CTRL_FIFO = 5;
  localparam int CTRL_DUAL = 6;
  localparam int CTRL_CASC = 7;
  localparam int CTRL_CASC_UPPER = 8;
  localparam int CTRL_WMODE_A = 9;
  localparam int CTRL_WMODE_B = 11;
  localparam logic [12:0] CTRL_RESET = 13'h0000;
  // width and threshold register fields
  localparam int WIDTH_A_LSB = 0;
  localparam int WIDTH_B_LSB = 4;
  localparam logic [7:0] WIDTH_RESET = 8'h55;
  localparam int THR_AF_LSB = 0;
  localparam int THR_AE_LSB = 16;
  localparam logic [12:0] AF_RESET = 13'h0f00;
  localparam logic [12:0] AE_RESET = 13'h0100;
  // status register fields
  localparam int ST_FULL = 16;
  localparam int ST_EMPTY = 17;
  localparam int ST_AFULL = 18;
  localparam int ST_AEMPTY = 19;
  localparam int ST_SBE = 20;
  localparam int ST_DBE = 21;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage : dpbm_pkg

// ==== verification/dpbm_asserts.sv ====
// port checker for the block memory
// assumes one aclk domain; bound into dpbm_top below
`timescale 1ns/1ps
`default_nettype none
module dpbm_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sleep,
  input wire logic [71:0] doutb,
  input wire logic fifo_full,
  input wire logic fifo_empty,
  input wire logic fifo_almost_empty,
  input wire logic [63:0] ecc_enc_data,
  input wire logic [7:0] ecc_enc_check,
  input wire logic [71:0] ecc_dec_word,
  input wire logic [63:0] ecc_dec_data,
  input wire logic ecc_dec_sbe,
  input wire logic ecc_dec_dbe,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // reset check must run while reset is low
  property p_rst;
    disable iff (1'h0) !aresetn |=> fifo_empty && !fifo_full && fifo_almost_empty;
  endproperty
  property p_excl; !(fifo_full && fifo_empty); endproperty
  // four gated cycles drain any read, output stage included
  property p_sleep; sleep [*4] |-> $stable(doutb); endproperty
  property p_enc; ecc_enc_data == 64'h0 |=> ecc_enc_check == 8'h0; endproperty
  property p_dec0; ecc_dec_word == 72'h0 |=> !ecc_dec_sbe && !ecc_dec_dbe; endproperty
  property p_dec1;
    ecc_dec_word == 72'h1 |=> ecc_dec_sbe && !ecc_dec_dbe && ecc_dec_data == 64'h0;
  endproperty
  property p_dec2; ecc_dec_word == 72'h3 |=> ecc_dec_dbe && !ecc_dec_sbe; endproperty
  property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rst: assert property (p_rst) else $error("flags wrong after reset");
  a_excl: assert property (p_excl) else $error("full and empty together");
  a_sleep: assert property (p_sleep) else $error("output moved while gated");
  a_enc: assert property (p_enc) else $error("check bits of zero word");
  a_dec0: assert property (p_dec0) else $error("clean word flagged");
  a_dec1: assert property (p_dec1) else $error("single error not fixed");
  a_dec2: assert property (p_dec2) else $error("double error not flagged");
  a_rd: assert property (p_rd) else $error("read answer late");
  c_sleep: cover property (sleep [*4]);
  c_sbe: cover property (ecc_dec_sbe);
  c_fill: cover property (!fifo_empty);
endmodule : dpbm_asserts
bind dpbm_top dpbm_asserts u_chk (.aclk, .aresetn, .sleep, .doutb, .fifo_full, .fifo_empty,
  .fifo_almost_empty, .ecc_enc_data, .ecc_enc_check, .ecc_dec_word, .ecc_dec_data,
  .ecc_dec_sbe, .ecc_dec_dbe, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);
`default_nettype wire

// ==== verification/dpbm_top_tb.sv ====
// self-checking bench for the block memory
// assumes 50 ns aclk; checker binds itself
`timescale 1ns/1ps
`default_nettype none
module dpbm_top_tb;
  logic aclk = 1'h0, aresetn = 1'h0, sleep = 1'h0, qa = 1'h0, wa = 1'h0, qb = 1'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, ena, wea, enb, web, sbiterr, dbiterr;
  logic fifo_full, fifo_empty, fifo_almost_full, fifo_almost_empty, ecc_dec_sbe, ecc_dec_dbe;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0, ecc_enc_check;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] addra, addrb, aa = 16'h0, ab = 16'h0;
  logic [71:0] dina, dinb, douta, doutb, casc_out, da = 72'h0, ecc_dec_word = 72'h0;
  logic [63:0] ecc_dec_data, ecc_enc_data = 64'h0;
  logic [15:0] ra [4] = '{16'h0, 16'h1, 16'h3ff, 16'h200};
  logic [35:0] rv [4] = '{36'h9_8765_4321, 36'h0_0000_0001, 36'hf_0f0f_0f0f, 36'h5_aaaa_5555};
  int num_errors = 0, check_count = 0;
  dpbm_user u_pa (.aclk, .req(qa), .wr(wa), .a(aa), .d(da), .en(ena), .we(wea), .addr(addra),
    .din(dina));
  dpbm_user u_pb (.aclk, .req(qb), .wr(1'h0), .a(ab), .d(72'h0), .en(enb), .we(web),
    .addr(addrb), .din(dinb));
  dpbm_top dut (.*, .s_axi_wstrb(4'hf), .casc_in(72'h0));
  always #25 aclk = ~aclk;
  task automatic chk(input logic [71:0] e, input logic [71:0] s, input string n);
    check_count++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic end_sim;
    if (num_errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  // one request pulse on port A; the partner adds one edge
  task automatic pa(input logic w, input logic [15:0] a, input logic [71:0] d);
    @(posedge aclk);
    {qa, wa, aa, da} <= {1'h1, w, a, d};
    @(posedge aclk);
    qa <= 1'h0;
  endtask : pa
  // port B read; ends as the word settles without the output stage
  task automatic rdb(input logic [15:0] a);
    @(posedge aclk);
    {qb, ab} <= {1'h1, a};
    @(posedge aclk);
    qb <= 1'h0;
    repeat (2) @(posedge aclk);
    #1;
  endtask : rdb
  // address and data offered together, each dropped when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
  endtask : axw
  task automatic rg(input logic [7:0] a, input logic [33:0] e, input string n);
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    chk(72'(e), 72'({s_axi_rresp, s_axi_rdata}), n);
  endtask : rg
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    rg(8'h00, 34'h0, "ctrl");
    rg(8'h04, 34'h55, "width");
    rg(8'h08, 34'h0100_0f00, "thresh");
    rg(8'h0c, 34'h000a_0000, "status");
    rg(8'h10, 34'h3_0000_0000, "unmapped");
    // rows: upper data bits must not leak into a 36-bit word
    foreach (rv[i]) pa(1'h1, ra[i], {36'hf_ffff_ffff, rv[i]});
    foreach (rv[i]) begin
      rdb(ra[i]);
      chk(rv[i], doutb[35:0], "row");
    end
    axw(8'h00, 32'h4);
    rdb(ra[0]);
    chk(rv[3], doutb[35:0], "oreg early");
    @(posedge aclk);
    #1;
    chk(rv[0], doutb[35:0], "oreg late");
    axw(8'h00, 32'h200);
    pa(1'h1, 16'h5, 72'h1_2345);
    repeat (3) @(posedge aclk);
    #1;
    chk(72'h1_2345, douta[35:0], "write first");
    @(posedge aclk);
    sleep <= 1'h1;
    pa(1'h1, ra[0], 72'h0);
    repeat (4) @(posedge aclk);
    sleep <= 1'h0;
    rdb(ra[0]);
    chk(rv[0], doutb[35:0], "sleep");
    // fifo: empty read dropped, a 36-bit word fills four lanes
    axw(8'h00, 32'h20);
    axw(8'h08, 32'h4);
    rdb(16'h0);
    rg(8'h0c, 34'h000a_0000, "empty read");
    pa(1'h1, 16'h0, 72'h7_7777);
    repeat (3) @(posedge aclk);
    rg(8'h0c, 34'h0004_0004, "one word");
    rdb(16'h0);
    chk(72'h7_7777, doutb[35:0], "fifo data");
    rg(8'h0c, 34'h000a_0000, "drained");
    {ecc_dec_word, ecc_enc_data} <= {72'h1, 64'h1};
    @(posedge aclk);
    #1;
    chk(72'h1, 72'(ecc_dec_sbe), "sbe");
    chk(72'h83, 72'(ecc_enc_check), "enc");
    @(posedge aclk);
    ecc_dec_word <= 72'h3;
    repeat (3) @(posedge aclk);
    end_sim;
  end
  // watchdog: the run needs just over a hundred cycles
  initial begin
    repeat (5000) @(posedge aclk);
    num_errors++;
    end_sim;
  end
endmodule : dpbm_top_tb
`default_nettype wire

// ==== verification/dpbm_user.sv ====
// user logic in front of one memory port
// assumes requests are pulsed by the bench on aclk
`timescale 1ns/1ps
`default_nettype none
module dpbm_user (
  input wire logic aclk,
  input wire logic req,
  input wire logic wr,
  input wire logic [15:0] a,
  input wire logic [71:0] d,
  output logic en,
  output logic we,
  output logic [15:0] addr,
  output logic [71:0] din
);
  initial {en, we, addr, din} = '0;
  // idle lines flip each cycle so a stale value never passes as valid
  always @(posedge aclk) begin
    en <= req;
    we <= req && wr;
    addr <= req ? a : ~addr;
    din <= req ? d : ~din;
  end
endmodule : dpbm_user
`default_nettype wire
